// File: shared/lcd_pkg.sv
// Constants, types and decode functions for the LCD frame timing core
package lcd_pkg;

    localparam int SEG_N     = 48;
    localparam int COM_N     = 4;
    localparam int RAM_WORDS = 8;

    // Word indices on the bus (byte address = 4 * index)
    localparam logic [5:0] IDX_MODE = 6'h00;
    localparam logic [5:0] IDX_STAT = 6'h01;
    localparam logic [5:0] IDX_RAM0 = 6'h04;
    localparam logic [5:0] IDX_RAML = 6'h0B;

    // Mode register field positions and reset value
    localparam int         MODE_MUX_LSB = 6;
    localparam int         MODE_HF_LSB  = 3;
    localparam int         MODE_LF_LSB  = 0;
    localparam logic [7:0] MODE_RST     = 8'h00;

    // Status register field positions
    localparam int STAT_RUN_BIT = 8;
    localparam int STAT_POL_BIT = 9;
    localparam int STAT_COM_LSB = 10;

    // Reference clock divider select codes
    localparam logic [2:0] HF_OFF  = 3'h0;
    localparam logic [2:0] HF_AUX  = 3'h1;
    localparam logic [2:0] HF_D32  = 3'h3;
    localparam logic [2:0] HF_D64  = 3'h4;
    localparam logic [2:0] HF_D128 = 3'h5;
    localparam logic [2:0] HF_D256 = 3'h6;

    // Divider terminal counts (factor minus one)
    localparam logic [7:0] HF_T32  = 8'h1F;
    localparam logic [7:0] HF_T64  = 8'h3F;
    localparam logic [7:0] HF_T128 = 8'h7F;
    localparam logic [7:0] HF_T256 = 8'hFF;

    localparam logic [8:0] LF_T512 = 9'h1FF;
    localparam logic [8:0] LF_T384 = 9'h17F;
    localparam logic [8:0] LF_T256 = 9'h0FF;
    localparam logic [8:0] LF_T192 = 9'h0BF;
    localparam logic [8:0] LF_T128 = 9'h07F;
    localparam logic [8:0] LF_T96  = 9'h05F;
    localparam logic [8:0] LF_T64  = 9'h03F;

    // Multiplex ratio codes
    localparam logic [1:0] MUX_4 = 2'h0;
    localparam logic [1:0] MUX_1 = 2'h1;
    localparam logic [1:0] MUX_2 = 2'h2;
    localparam logic [1:0] MUX_3 = 2'h3;

    // Pin drive levels
    localparam logic [1:0] LVL_GND   = 2'h0;
    localparam logic [1:0] LVL_THIRD = 2'h1;
    localparam logic [1:0] LVL_TWO3  = 2'h2;
    localparam logic [1:0] LVL_FULL  = 2'h3;

    typedef struct packed {
        logic [1:0] mux;
        logic [2:0] hf;
        logic [2:0] lf;
    } lcd_mode_t;

    typedef struct packed {
        logic [COM_N-1:0][1:0] com;
        logic [SEG_N-1:0][1:0] seg;
        logic                  bias_en;
        logic                  half_bias;
    } lcd_drive_t;

    typedef enum logic {
        LCD_OFF,
        LCD_RUN
    } lcd_state_t;

    function automatic logic hf_valid(input logic [2:0] hf);
        hf_valid = (hf == HF_AUX) || (hf == HF_D32) || (hf == HF_D64) ||
                   (hf == HF_D128) || (hf == HF_D256);
    endfunction

    function automatic logic [7:0] hf_term(input logic [2:0] hf);
        case (hf)
            HF_D32:  hf_term = HF_T32;
            HF_D64:  hf_term = HF_T64;
            HF_D128: hf_term = HF_T128;
            default: hf_term = HF_T256;
        endcase
    endfunction

    function automatic logic [8:0] lf_term(input logic [2:0] lf);
        case (lf)
            3'h1:    lf_term = LF_T384;
            3'h2:    lf_term = LF_T256;
            3'h3:    lf_term = LF_T192;
            3'h4:    lf_term = LF_T128;
            3'h5:    lf_term = LF_T96;
            3'h6:    lf_term = LF_T64;
            default: lf_term = LF_T512;
        endcase
    endfunction

    function automatic logic [1:0] com_last(input logic [1:0] mux);
        case (mux)
            MUX_1:   com_last = 2'h0;
            MUX_2:   com_last = 2'h1;
            MUX_3:   com_last = 2'h2;
            default: com_last = 2'h3;
        endcase
    endfunction

endpackage

// File: rtl/lcd_ref_div.sv
// Reference tick generator: divided core clock or auxiliary oscillator
`timescale 1ns/1ps
`default_nettype none
module lcd_ref_div
    import lcd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       run_i,
    input  wire logic [2:0] hf_i,
    input  wire logic       aux_clk_i,
    output logic            tick_o
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       aux_s1_r;
    logic       aux_s2_r;
    logic       aux_s3_r;
    logic       tick_r;
    logic       tick_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!run_i || !hf_valid(hf_i))
        begin
            cnt_nxt = 8'h00;
        end
        else if (hf_i == HF_AUX)
        begin
            tick_nxt = aux_s2_r & ~aux_s3_r;
        end
        else if (cnt_r >= hf_term(hf_i))
        begin
            cnt_nxt  = 8'h00;
            tick_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r    <= 8'h00;
            tick_r   <= 1'b0;
            aux_s1_r <= 1'b0;
            aux_s2_r <= 1'b0;
            aux_s3_r <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_r    <= cnt_nxt;
            tick_r   <= tick_nxt;
            aux_s1_r <= aux_clk_i;
            aux_s2_r <= aux_s1_r;
            aux_s3_r <= aux_s2_r;
        end
    end

    assign tick_o = tick_r;

endmodule // lcd_ref_div
`default_nettype wire

// File: rtl/lcd_mux_frame_timing.sv
// LCD multiplexed frame timing core with Wishbone register slave
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module lcd_mux_frame_timing
    import lcd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        aux_clk_i,
    input  wire logic        osc_fail_i,
    input  wire logic        stop_mode_i,
    output lcd_drive_t       drive_o
);

    // Byte lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = wr[8*b +: 8];
            end
        end
        merge = res;
    endfunction

    // Register and bus state
    lcd_mode_t   mode_r;
    lcd_mode_t   mode_nxt;
    logic [31:0] ram_r [RAM_WORDS];
    logic [31:0] ram_nxt [RAM_WORDS];
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        ack_r;
    logic        ack_nxt;

    // Timing state
    lcd_state_t  st_r;
    lcd_state_t  st_nxt;
    lcd_mode_t   act_r;
    lcd_mode_t   act_nxt;
    logic [8:0]  div_r;
    logic [8:0]  div_nxt;
    logic [1:0]  com_r;
    logic [1:0]  com_nxt;
    logic        pol_r;
    logic        pol_nxt;
    lcd_drive_t  drv_r;
    lcd_drive_t  drv_nxt;

    logic        ref_tick;
    logic        fault;
    logic        bus_req;
    logic [5:0]  idx;
    logic [2:0]  ram_idx;
    logic [SEG_N-1:0] row;
    logic [SEG_N-1:0][1:0] seg_lvl;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign idx     = wb_adr_i[7:2];
    assign ram_idx = 3'(idx - IDX_RAM0);

    always_comb
    begin
        mode_nxt = mode_r;
        ram_nxt  = ram_r;
        dat_nxt  = 32'h0000_0000;
        ack_nxt  = bus_req;
        if (bus_req)
        begin
            if (idx == IDX_MODE)
            begin
                dat_nxt = {24'h00_0000, mode_r};
                if (wb_we_i && wb_sel_i[0])
                begin
                    mode_nxt = lcd_mode_t'(wb_dat_i[7:0]);
                end
            end
            else if (idx == IDX_STAT)
            begin
                dat_nxt = {20'h0_0000, com_r, pol_r, (st_r == LCD_RUN), act_r};
            end
            else if (idx >= IDX_RAM0 && idx <= IDX_RAML)
            begin
                dat_nxt = ram_r[ram_idx];
                if (wb_we_i)
                begin
                    ram_nxt[ram_idx] = merge(ram_r[ram_idx], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r <= lcd_mode_t'(MODE_RST);
            dat_r  <= 32'h0000_0000;
            ack_r  <= 1'b0;
            for (int i = 0; i < RAM_WORDS; i++)
            begin
                ram_r[i] <= 32'h0000_0000;
            end
        end
        else if (ce_i)
        begin
            mode_r <= mode_nxt;
            ram_r  <= ram_nxt;
            dat_r  <= dat_nxt;
            ack_r  <= ack_nxt;
        end
    end

    lcd_ref_div u_ref_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .run_i     (st_r == LCD_RUN),
        .hf_i      (act_r.hf),
        .aux_clk_i (aux_clk_i),
        .tick_o    (ref_tick)
    );

    assign fault = osc_fail_i | (stop_mode_i & (act_r.hf != HF_AUX));

    always_comb
    begin
        st_nxt  = st_r;
        act_nxt = act_r;
        div_nxt = div_r;
        com_nxt = com_r;
        pol_nxt = pol_r;
        case (st_r)
            LCD_OFF:
            begin
                div_nxt = 9'h000;
                com_nxt = 2'h0;
                pol_nxt = 1'b0;
                act_nxt = mode_r;
                // display off while select is 000, 010 or 111
                if (hf_valid(mode_r.hf) && !osc_fail_i &&
                    !(stop_mode_i && mode_r.hf != HF_AUX))
                begin
                    st_nxt = LCD_RUN;
                end
            end
            LCD_RUN:
            begin
                if (fault)
                begin
                    st_nxt = LCD_OFF;
                end
                else if (ref_tick)
                begin
                    if (div_r >= lf_term(act_r.lf))
                    begin
                        div_nxt = 9'h000;
                        if (com_r >= com_last(act_r.mux))
                        begin
                            com_nxt = 2'h0;
                            pol_nxt = ~pol_r;
                            // new mode only at frame end
                            act_nxt = mode_r;
                            if (!hf_valid(mode_r.hf))
                            begin
                                st_nxt = LCD_OFF;
                            end
                        end
                        else
                        begin
                            com_nxt = com_r + 2'h1;
                        end
                    end
                    else
                    begin
                        div_nxt = div_r + 9'h001;
                    end
                end
            end
            default:
            begin
                st_nxt = LCD_OFF;
            end
        endcase
    end

    // row of RAM for the selected common
    assign row = {ram_r[{com_r, 1'b1}][SEG_N-33:0], ram_r[{com_r, 1'b0}]};

    genvar s;
    generate
        for (s = 0; s < SEG_N; s++)
        begin : g_seg
            always_comb
            begin
                if (row[s])
                begin
                    seg_lvl[s] = pol_r ? LVL_GND : LVL_FULL;
                end
                else if (act_r.mux == MUX_1)
                begin
                    seg_lvl[s] = pol_r ? LVL_FULL : LVL_GND;
                end
                else
                begin
                    seg_lvl[s] = pol_r ? LVL_TWO3 : LVL_THIRD;
                end
            end
        end
    endgenerate

    always_comb
    begin
        drv_nxt = '0;
        if (st_r == LCD_RUN && !fault)
        begin
            // bias divider on only while driving
            drv_nxt.bias_en = 1'b1;
            drv_nxt.half_bias = (act_r.mux == MUX_2);
            drv_nxt.seg = seg_lvl;
            for (int c = 0; c < COM_N; c++)
            begin
                if (c == int'(com_r))
                begin
                    drv_nxt.com[c] = pol_r ? LVL_FULL : LVL_GND;
                end
                else if (c <= int'(com_last(act_r.mux)))
                begin
                    drv_nxt.com[c] = pol_r ? LVL_THIRD : LVL_TWO3;
                end
                else
                begin
                    drv_nxt.com[c] = LVL_GND;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r  <= LCD_OFF;
            act_r <= lcd_mode_t'(MODE_RST);
            div_r <= 9'h000;
            com_r <= 2'h0;
            pol_r <= 1'b0;
            drv_r <= '0;
        end
        else if (ce_i)
        begin
            st_r  <= st_nxt;
            act_r <= act_nxt;
            div_r <= div_nxt;
            com_r <= com_nxt;
            pol_r <= pol_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign drive_o  = drv_r;

endmodule // lcd_mux_frame_timing
`default_nettype wire

// File: bench/lcd_mux_frame_timing_monitor.sv
// Port checker for the LCD frame timing core
`timescale 1ns/1ps
`default_nettype none
module lcd_mux_frame_timing_monitor
    import lcd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        osc_fail_i,
    input wire lcd_drive_t  drive_o
);
    logic [1:0]  prev_r;
    logic [15:0] run_r;
    logic [15:0] run_nxt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since common zero last moved
    always_comb
    begin
        run_nxt = (run_r == 16'hFFFF) ? run_r : run_r + 16'h0001;
        if (drive_o.com[0] != prev_r)
            run_nxt = 16'h0000;
    end
    always_ff @(posedge clk_i)
    begin
        prev_r <= drive_o.com[0];
        run_r  <= rst_i ? 16'h0000 : run_nxt;
    end
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked");
    property p_ack_pulse;
        wb_ack_o && ce_i |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_fault_gnd;
        osc_fail_i && ce_i |-> ##2 drive_o == '0;
    endproperty
    a_fault_gnd: assert property (p_fault_gnd) else $error("fault left drive");
    property p_bias_off;
        !drive_o.bias_en |-> drive_o.com == '0 && drive_o.seg == '0;
    endproperty
    a_bias_off: assert property (p_bias_off) else $error("drive without bias");
    property p_half;
        drive_o.half_bias |-> drive_o.bias_en && drive_o.com[3:2] == '0;
    endproperty
    a_half: assert property (p_half) else $error("half bias misuse");
    property p_one_full;
        $onehot0({drive_o.com[3] == LVL_FULL, drive_o.com[2] == LVL_FULL,
                  drive_o.com[1] == LVL_FULL, drive_o.com[0] == LVL_FULL});
    endproperty
    a_one_full: assert property (p_one_full) else $error("two commons selected");
    property p_seg_lvl;
        drive_o.com[0] == LVL_FULL |-> drive_o.seg[0] != LVL_THIRD;
    endproperty
    a_seg_lvl: assert property (p_seg_lvl) else $error("segment level wrong");
    property p_slot;
        drive_o.com[0] != prev_r && drive_o.bias_en && $past(drive_o.bias_en, 2)
            |-> run_r > 16'h0700;
    endproperty
    a_slot: assert property (p_slot) else $error("common slot too short");
endmodule // lcd_mux_frame_timing_monitor
bind lcd_mux_frame_timing lcd_mux_frame_timing_monitor u_lcd_mux_frame_timing_monitor (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_ack_o   (wb_ack_o),
    .wb_dat_o   (wb_dat_o),
    .osc_fail_i (osc_fail_i),
    .drive_o    (drive_o)
);
`default_nettype wire

// File: bench/lcd_panel_model.sv
// Glass panel model: lit elements and DC sum on common zero
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
    import lcd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire lcd_drive_t drive_i,
    output logic [1:0]      lit_o,
    output int              dc_o
);
    always_ff @(posedge clk_i)
    begin
        if (clr_i)
        begin
            lit_o <= 2'b00;
            dc_o  <= 0;
        end
        else
        begin
            // Full swing across an element lights it
            for (int s = 0; s < 2; s++)
                if ({drive_i.com[0], drive_i.seg[s]} inside {4'hC, 4'h3})
                    lit_o[s] <= 1'b1;
            dc_o <= dc_o + int'(drive_i.com[0]) - int'(drive_i.seg[0]);
        end
    end
endmodule // lcd_panel_model
`default_nettype wire

// File: bench/lcd_mux_frame_timing_tb.sv
// Testbench for the LCD frame timing core
`timescale 1ns/1ps
`default_nettype none
module lcd_mux_frame_timing_tb
    import lcd_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic [4:0]  aux_div = 5'h00;
    lcd_drive_t  snap;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        aux_clk_i;
    logic        osc_fail_i;
    logic        stop_mode_i;
    logic        clr;
    logic [1:0]  lit;
    int          dc;
    lcd_drive_t  drive_o;
    int          errors;
    int          n_checks;
    int          cycles;
    logic [7:0]  cur;
    logic [31:0] q;
    int          n;
    logic [7:0]  modes [6] = '{8'h5D, 8'h66, 8'h9E, 8'hDE, 8'h1E, 8'h4E};
    int          frames [6] = '{3072, 4096, 4096, 6144, 8192, 2048};

    lcd_mux_frame_timing u_lcd_mux_frame_timing (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .wb_cyc_i    (cyc),
        .wb_stb_i    (stb),
        .wb_we_i     (we),
        .wb_adr_i    (adr),
        .wb_sel_i    (sel),
        .wb_dat_i    (wdat),
        .wb_dat_o    (rdat),
        .wb_ack_o    (ack),
        .aux_clk_i   (aux_clk_i),
        .osc_fail_i  (osc_fail_i),
        .stop_mode_i (stop_mode_i),
        .drive_o     (drive_o)
    );
    lcd_panel_model u_lcd_panel_model (
        .clk_i   (clk_i),
        .clr_i   (clr),
        .drive_i (drive_o),
        .lit_o   (lit),
        .dc_o    (dc)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Auxiliary oscillator, one period per 32 core clocks
    always @(posedge clk_i)
    begin
        aux_div   <= aux_div + 5'h01;
        aux_clk_i <= aux_div[4];
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int t;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        t = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && t < 64)
        begin
            @(posedge clk_i);
            t++;
        end
        r = rdat;
        chk("ack", 32'h0000_0001, 32'(t < 64));
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_lvl(input logic [1:0] lv, output int k);
        logic [1:0] p;
        p = drive_o.com[0];
        k = 1;
        @(posedge clk_i);
        while (!(drive_o.com[0] === lv && p !== lv) && k < 40000)
        begin
            p = drive_o.com[0];
            @(posedge clk_i);
            k++;
        end
    endtask
    task automatic wait_off(output int k);
        k = 0;
        while (drive_o !== '0 && k < 20000)
        begin
            @(posedge clk_i);
            k++;
        end
    endtask
    task automatic run_mode(input logic [7:0] m, input int fr);
        int         nc;
        int         tol;
        logic [7:0] ec;
        nc = (m[7:6] == MUX_4) ? 4 : int'(m[7:6]);
        tol = (m[5:3] == HF_AUX || cur[5:3] == HF_AUX) ? 40 : 0;
        ec = 8'h00;
        for (int i = 1; i < nc; i++)
            ec[2*i +: 2] = LVL_TWO3;
        wb(1'b1, 8'h00, {24'h00_0000, m}, 4'h1, q);
        wb(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
        chk("stat_mode", {24'h00_0000, cur}, {24'h00_0000, q[7:0]});
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hF, q);
        chk("mode", {24'h00_0000, m}, q);
        cur = m;
        wait_lvl(LVL_FULL, n);
        wait_lvl(LVL_GND, n);
        chk("frame", 32'h0000_0001, 32'(n <= fr && n >= fr - tol));
        chk("commons", {24'h00_0000, ec}, 32'(drive_o.com));
        chk("half", 32'(m[7:6] == MUX_2), 32'(drive_o.half_bias));
        $display("mode %h done", m);
    endtask

    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        osc_fail_i = 1'b0;
        stop_mode_i = 1'b0;
        clr = 1'b1;
        cur = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        clr <= 1'b0;
        @(posedge clk_i);
        chk("drive_rst", 32'h0000_0000, 32'(drive_o !== '0));
        wb(1'b1, 8'h00, 32'h0000_005E, 4'h0, q);
        wb(1'b1, 8'h04, 32'h0000_00FF, 4'hF, q);
        wb(1'b0, 8'h08, 32'h0000_0000, 4'hF, q);
        chk("unmapped", 32'h0000_0000, q);
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hF, q);
        chk("mode_rst", 32'h0000_0000, q);
        wb(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
        chk("stat_rst", 32'h0000_0000, q);
        wb(1'b1, 8'h10, 32'h0000_0001, 4'hF, q);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hF, q);
        chk("ram", 32'h0000_0001, q);
        wb(1'b1, 8'h00, 32'h0000_005E, 4'h1, q);
        cur = 8'h5E;
        wait_lvl(LVL_FULL, n);
        chk("bias", 32'h0000_0001, 32'(drive_o.bias_en));
        chk("seg_on", 32'(LVL_GND), 32'(drive_o.seg[0]));
        chk("seg_off", 32'(LVL_FULL), 32'(drive_o.seg[1]));
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wait_lvl(LVL_FULL, n);
        chk("dc", 32'h0000_0001, 32'(dc > -16 && dc < 16));
        chk("lit", 32'h0000_0001, 32'(lit));
        $display("static done");
        ce_i <= 1'b0;
        @(posedge clk_i);
        snap = drive_o;
        repeat (40) @(posedge clk_i);
        chk("ce_hold", 32'h0000_0000, 32'(drive_o !== snap));
        ce_i <= 1'b1;
        $display("freeze done");
        foreach (modes[i]) run_mode(modes[i], frames[i]);
        stop_mode_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("aux_stop", 32'h0000_0001, 32'(drive_o.bias_en));
        stop_mode_i <= 1'b0;
        run_mode(8'h5E, 2048);
        stop_mode_i <= 1'b1;
        wait_off(n);
        chk("stop_off", 32'h0000_0000, 32'(drive_o !== '0));
        stop_mode_i <= 1'b0;
        wait_lvl(LVL_FULL, n);
        osc_fail_i <= 1'b1;
        wait_off(n);
        chk("fail_off", 32'h0000_0001, 32'(n <= 3));
        osc_fail_i <= 1'b0;
        wait_lvl(LVL_FULL, n);
        wb(1'b1, 8'h00, 32'h0000_0000, 4'h1, q);
        wait_off(n);
        chk("off_write", 32'h0000_0001, 32'(n <= 2100));
        $display("stop and fault done");
        close_out();
    end
endmodule // lcd_mux_frame_timing_tb
`default_nettype wire
